// >>> include/emcc_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the MAC control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Definitions only
`ifndef EMCC_DEFINES_SVH
`define EMCC_DEFINES_SVH
`define EMCC_ADDR_NET_CTRL 8'h00
`define EMCC_ADDR_NET_CFG 8'h04
`define EMCC_ADDR_NET_STAT 8'h08
`define EMCC_ADDR_TX_STAT 8'h14
`define EMCC_ADDR_MGMT_SHIFT 8'h34
`define EMCC_ADDR_HASH_LO 8'h90
`define EMCC_ADDR_HASH_HI 8'h94
`define EMCC_CTL_LOOPBACK 1
`define EMCC_CTL_RX_EN 2
`define EMCC_CTL_TX_EN 3
`define EMCC_CTL_MGMT_EN 4
`define EMCC_CTL_STATS_CLR 5
`define EMCC_CTL_RW_MASK 32'h0000001E
`define EMCC_CFG_FULL_DUPLEX 1
`define EMCC_CFG_SERIAL 2
`define EMCC_CFG_OVERSIZE 3
`define EMCC_CFG_MCAST_HASH 6
`define EMCC_CFG_UCAST_HASH 7
`define EMCC_CFG_LONG_FRAME 8
`define EMCC_CFG_DIV_LO 10
`define EMCC_CFG_RETRY_TEST 12
`define EMCC_CFG_PAUSE_EN 13
`define EMCC_CFG_LEN_CHECK 16
`define EMCC_CFG_RX_WHILE_TX 18
`define EMCC_CFG_IGNORE_FCS 19
`define EMCC_CFG_RW_MASK 32'h000FFDFE
`define EMCC_CFG_RESET 32'h00000800
`define EMCC_STAT_PIN_LEVEL 1
`define EMCC_STAT_IDLE 2
`define EMCC_TXS_USED 0
`define EMCC_TXS_COLL 1
`define EMCC_TXS_RETRY 2
`define EMCC_TXS_GO 3
`define EMCC_TXS_BUFEX 4
`define EMCC_TXS_DONE 5
`define EMCC_TXS_UNDER 6
`define EMCC_TXS_W1C_MASK 7'h77
`define EMCC_LEN_TYPE_MIN 16'h0600
`define EMCC_LEN_STD 14'h05EE
`define EMCC_LEN_LONG 14'h0600
`define EMCC_LEN_JUMBO 14'h2800
`define EMCC_MDC_HALF_DIV8 5'h04
`define EMCC_MDC_HALF_DIV16 5'h08
`define EMCC_MDC_HALF_DIV32 5'h10
`define EMCC_MGMT_BITS 6'h20
`define EMCC_MGMT_TA_BIT 6'h0E
`define EMCC_LOOP_DIV 2'h3
`endif

// >>> include/emcc_pkg.sv
// Purpose: Types shared by the MAC control block files
// Assumes: Constants live in emcc_defines.svh
// Notes: Gray-coded management states
package emcc_pkg;
  typedef enum logic [1:0] {
    EMCC_MG_IDLE = 2'h0,
    EMCC_MG_LOW = 2'h1,
    EMCC_MG_HIGH = 2'h3
  } emcc_mgmt_state_type;
  typedef struct packed {
    logic [3:0] data;
    logic valid;
    logic carrier;
    logic collision;
  } emcc_rx_line_type;
  typedef struct packed {
    logic [3:0] data;
    logic enable;
    logic error;
  } emcc_tx_line_type;
  typedef struct packed {
    logic done;
    logic crc_ok;
    logic [13:0] length;
    logic [15:0] len_field;
    logic unicast;
    logic multicast;
    logic [5:0] hash_idx;
    logic addr_match;
  } emcc_rx_frame_type;
  typedef struct packed {
    logic used_bit;
    logic collision;
    logic retry_limit;
    logic buf_exhausted;
    logic done;
    logic underrun;
  } emcc_tx_event_type;
endpackage

// >>> rtl/emcc_mgmt.sv
// Purpose: Serial management port shifter and clock divider
// Assumes: Pin input already crosses two flops here before use
// Notes: Shift register holds the 32 sampled pin bits after a full frame
`include "emcc_defines.svh"
module emcc_mgmt
  import emcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic port_en,
  input wire logic [1:0] div_code,
  input wire logic start,
  input wire logic [31:0] wdata,
  input wire logic pin_in,
  output logic [31:0] shift_data,
  output logic idle,
  output logic done,
  output logic pin_level,
  output logic clk_out,
  output logic data_out,
  output logic data_oe_n
);
  emcc_mgmt_state_type state;
  logic [4:0] cnt;
  logic [4:0] half;
  logic [5:0] bits;
  logic pin_s1;
  logic is_read;

  always_comb begin
    case (div_code)
      2'h0: half = `EMCC_MDC_HALF_DIV8;
      2'h1: half = `EMCC_MDC_HALF_DIV16;
      default: half = `EMCC_MDC_HALF_DIV32;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      pin_s1 <= pin_in;
      pin_level <= pin_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= EMCC_MG_IDLE;
      cnt <= 5'h0;
      bits <= 6'h0;
      shift_data <= 32'h0;
      idle <= 1'b1;
      done <= 1'b0;
      is_read <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        EMCC_MG_IDLE: begin
          if (start) begin
            shift_data <= wdata;
            is_read <= wdata[29:28] == 2'h2;
            idle <= 1'b0;
            cnt <= 5'h0;
            bits <= 6'h0;
            state <= EMCC_MG_LOW;
          end
        end
        EMCC_MG_LOW: begin
          cnt <= cnt + 5'h1;
          if (cnt + 5'h1 >= half) begin
            cnt <= 5'h0;
            shift_data <= {shift_data[30:0], pin_level};
            bits <= bits + 6'h1;
            state <= EMCC_MG_HIGH;
          end
        end
        EMCC_MG_HIGH: begin
          cnt <= cnt + 5'h1;
          if (cnt + 5'h1 >= half) begin
            cnt <= 5'h0;
            if (bits == `EMCC_MGMT_BITS) begin
              idle <= 1'b1;
              done <= 1'b1;
              state <= EMCC_MG_IDLE;
            end else begin
              state <= EMCC_MG_LOW;
            end
          end
        end
        default: state <= EMCC_MG_IDLE;
      endcase
    end
  end

  // Read frames release the pin from turnaround so the PHY can answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out <= 1'b0;
      data_out <= 1'b0;
      data_oe_n <= 1'b1;
    end else if (!port_en) begin
      clk_out <= 1'b0;
      data_out <= 1'b0;
      data_oe_n <= 1'b1;
    end else begin
      clk_out <= state == EMCC_MG_HIGH;
      data_out <= shift_data[31];
      data_oe_n <= (state == EMCC_MG_IDLE) || (is_read && bits >= `EMCC_MGMT_TA_BIT);
    end
  end
endmodule

// >>> rtl/emcc_line.sv
// Purpose: Line pin synchronisers, loopback and serial-mode steering
// Assumes: Line pins are asynchronous to pclk
// Notes: Loopback clock is a pclk/4 tick, not a real clock
`include "emcc_defines.svh"
module emcc_line
  import emcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic loopback,
  input wire logic serial,
  input wire emcc_tx_line_type core_tx,
  input wire emcc_rx_line_type pins_rx,
  output emcc_tx_line_type pins_tx,
  output emcc_rx_line_type core_rx,
  output logic loop_tick
);
  emcc_rx_line_type s1;
  emcc_rx_line_type s2;
  logic [1:0] div;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= pins_rx;
      s2 <= s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 2'h0;
      loop_tick <= 1'b0;
    end else begin
      div <= div + 2'h1;
      loop_tick <= loopback && div == `EMCC_LOOP_DIV;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_tx <= '0;
      core_rx <= '0;
    end else begin
      pins_tx.enable <= core_tx.enable && !loopback;
      pins_tx.error <= core_tx.error && !loopback;
      pins_tx.data <= serial ? {3'h0, core_tx.data[0]} : core_tx.data;
      if (loopback) begin
        core_rx.data <= core_tx.data;
        core_rx.valid <= core_tx.enable;
        core_rx.carrier <= 1'b0;
        core_rx.collision <= 1'b0;
      end else begin
        core_rx.data <= serial ? {3'h0, s2.data[0]} : s2.data;
        core_rx.valid <= serial ? (s2.carrier || s2.valid) : s2.valid;
        core_rx.carrier <= s2.carrier;
        core_rx.collision <= s2.collision;
      end
    end
  end
endmodule

// >>> rtl/emcc_ctrl.sv
// Purpose: Control, configuration and status registers of the MAC
// Assumes: APB slave, zero wait states; core logic on pclk
// Notes: Statistics, descriptor engines and interrupts live elsewhere
//
// The APB interface to the registers was chosen for this implementation.
`include "emcc_defines.svh"
// What this block does
// - Writing one to stats clear pulses a clear of all statistics counters.
// - Management port disabled keeps data pin released and clock pin low.
// - Dropping transmit enable stops transmit, flushes it, rewinds queue pointer.
// - Dropping receive enable stops receive and flushes it; pointer untouched.
// - Loopback ties transmit to receive, forces full duplex, clocks at pclk/4.
// - Ignore-FCS accepts CRC-bad frames and counts no FCS error.
// - Half-duplex receive while transmitting only when its bit is set.
// - Length check drops frames shorter than length field, except type values.
// - Pause enable lets valid received pause frames pause the transmitter.
// - Retry test gives one-slot backoff and per-receive-clock pause decrement.
// - Divisor codes 0,1,2 give 8,16,32; resets to 32; 3 invalid, here stored and treated as 32.
// - Long-frame bit accepts up to 1536 bytes, else above 1518 rejected.
// - Hash enables accept unicast or multicast frames whose hash bit is set.
// - Oversize bit accepts frames up to 10240 bytes.
// - Serial mode uses data bit 0 only and carrier OR valid; loopback receive still takes all 4 bits and tx enable.
// - Full duplex ignores collision and carrier, allows receive while sending.
// - Status shows management idle in bit 2 and data pin level in bit 1.
// - Transmit status flags clear by writing one; writes never set them.
// - Underrun forces bad CRC, raises transmit error pin, sets underrun flag.
// - Frame transmitted sets transmit done flag in bit 5.
// - Buffers exhausted mid-frame gives bad FCS, error pin, flag set; frame not stopped.
// - Writing the management shift register while idle starts a frame; idle low meanwhile.
module emcc_ctrl
  import emcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire emcc_tx_line_type core_tx,
  input wire emcc_tx_event_type tx_evt,
  input wire logic tx_active,
  input wire emcc_rx_frame_type rx_frame,
  input wire logic rx_pause_frame,
  input wire logic pause_slot_tick,
  input wire logic rx_clk_tick,
  input wire emcc_rx_line_type pins_rx,
  input wire logic mgmt_data_in,
  output emcc_tx_line_type pins_tx,
  output emcc_rx_line_type core_rx,
  output logic mgmt_clock_pin,
  output logic mgmt_data_out,
  output logic mgmt_data_oe_n,
  output logic loop_tick,
  output logic stats_clear,
  output logic tx_flush,
  output logic tx_queue_rewind,
  output logic rx_flush,
  output logic tx_run,
  output logic rx_run,
  output logic rx_accept,
  output logic rx_reject,
  output logic fcs_err_count,
  output logic tx_col_seen,
  output logic tx_crs_seen,
  output logic rx_allowed,
  output logic pause_start,
  output logic pause_dec,
  output logic backoff_one_slot,
  output logic force_bad_crc,
  output logic mgmt_done
);
  logic [31:0] net_ctrl;
  logic [31:0] net_cfg;
  logic [6:0] tx_stat;
  logic [63:0] hash;
  logic [31:0] next_prdata;
  logic next_err;
  logic wr;
  logic mgmt_start;
  logic mgmt_idle;
  logic mgmt_level;
  logic [31:0] mgmt_data;
  logic tx_err_hold;
  logic full_duplex;
  logic [13:0] max_len;
  emcc_tx_line_type core_tx_q;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    is_addr = a == r;
  endfunction

  assign wr = psel && penable && pready && pwrite;
  assign mgmt_start = wr && is_addr(paddr, `EMCC_ADDR_MGMT_SHIFT) && mgmt_idle;
  assign full_duplex = net_cfg[`EMCC_CFG_FULL_DUPLEX] || net_ctrl[`EMCC_CTL_LOOPBACK];

  // Read data prepared in setup so every bus output comes from a flop
  always_comb begin
    next_prdata = 32'h0;
    next_err = 1'b0;
    if (is_addr(paddr, `EMCC_ADDR_NET_CTRL)) begin
      next_prdata = net_ctrl & `EMCC_CTL_RW_MASK;
    end else if (is_addr(paddr, `EMCC_ADDR_NET_CFG)) begin
      next_prdata = net_cfg;
    end else if (is_addr(paddr, `EMCC_ADDR_NET_STAT)) begin
      next_prdata[`EMCC_STAT_IDLE] = mgmt_idle;
      next_prdata[`EMCC_STAT_PIN_LEVEL] = mgmt_level;
    end else if (is_addr(paddr, `EMCC_ADDR_TX_STAT)) begin
      next_prdata = {25'h0, tx_stat};
    end else if (is_addr(paddr, `EMCC_ADDR_MGMT_SHIFT)) begin
      next_prdata = mgmt_data;
    end else if (is_addr(paddr, `EMCC_ADDR_HASH_LO)) begin
      next_prdata = hash[31:0];
    end else if (is_addr(paddr, `EMCC_ADDR_HASH_HI)) begin
      next_prdata = hash[63:32];
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Command bits stored only for their one-cycle action
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_ctrl <= 32'h0;
      stats_clear <= 1'b0;
      tx_flush <= 1'b0;
      tx_queue_rewind <= 1'b0;
      rx_flush <= 1'b0;
    end else begin
      stats_clear <= 1'b0;
      tx_flush <= 1'b0;
      tx_queue_rewind <= 1'b0;
      rx_flush <= 1'b0;
      if (wr && is_addr(paddr, `EMCC_ADDR_NET_CTRL)) begin
        net_ctrl <= pwdata & `EMCC_CTL_RW_MASK;
        stats_clear <= pwdata[`EMCC_CTL_STATS_CLR];
        if (net_ctrl[`EMCC_CTL_TX_EN] && !pwdata[`EMCC_CTL_TX_EN]) begin
          tx_flush <= 1'b1;
          tx_queue_rewind <= 1'b1;
        end
        if (net_ctrl[`EMCC_CTL_RX_EN] && !pwdata[`EMCC_CTL_RX_EN]) begin
          rx_flush <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_run <= 1'b0;
      rx_run <= 1'b0;
    end else begin
      tx_run <= net_ctrl[`EMCC_CTL_TX_EN];
      rx_run <= net_ctrl[`EMCC_CTL_RX_EN];
    end
  end

  // Divisor code 3 is stored as written; the divider treats it as 32
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_cfg <= `EMCC_CFG_RESET;
    end else if (wr && is_addr(paddr, `EMCC_ADDR_NET_CFG)) begin
      net_cfg <= pwdata & `EMCC_CFG_RW_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hash <= 64'h0;
    end else if (wr && is_addr(paddr, `EMCC_ADDR_HASH_LO)) begin
      hash[31:0] <= pwdata;
    end else if (wr && is_addr(paddr, `EMCC_ADDR_HASH_HI)) begin
      hash[63:32] <= pwdata;
    end
  end

  // Hardware set beats a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_stat <= 7'h0;
    end else begin
      if (wr && is_addr(paddr, `EMCC_ADDR_TX_STAT)) begin
        tx_stat <= tx_stat & ~(pwdata[6:0] & `EMCC_TXS_W1C_MASK);
      end
      tx_stat[`EMCC_TXS_GO] <= tx_active;
      if (tx_evt.used_bit) tx_stat[`EMCC_TXS_USED] <= 1'b1;
      if (tx_evt.collision) tx_stat[`EMCC_TXS_COLL] <= 1'b1;
      if (tx_evt.retry_limit) tx_stat[`EMCC_TXS_RETRY] <= 1'b1;
      if (tx_evt.buf_exhausted) tx_stat[`EMCC_TXS_BUFEX] <= 1'b1;
      if (tx_evt.done) tx_stat[`EMCC_TXS_DONE] <= 1'b1;
      if (tx_evt.underrun) tx_stat[`EMCC_TXS_UNDER] <= 1'b1;
    end
  end

  // Error lasts to the end of the frame the core is sending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_err_hold <= 1'b0;
      force_bad_crc <= 1'b0;
    end else begin
      if (tx_evt.underrun || tx_evt.buf_exhausted) begin
        tx_err_hold <= 1'b1;
      end else if (!core_tx.enable) begin
        tx_err_hold <= 1'b0;
      end
      force_bad_crc <= tx_evt.underrun || tx_evt.buf_exhausted;
    end
  end

  always_comb begin
    core_tx_q = core_tx;
    core_tx_q.enable = core_tx.enable && net_ctrl[`EMCC_CTL_TX_EN];
    core_tx_q.error = core_tx.error || tx_err_hold;
  end

  always_comb begin
    if (net_cfg[`EMCC_CFG_OVERSIZE]) begin
      max_len = `EMCC_LEN_JUMBO;
    end else if (net_cfg[`EMCC_CFG_LONG_FRAME]) begin
      max_len = `EMCC_LEN_LONG;
    end else begin
      max_len = `EMCC_LEN_STD;
    end
  end

  // Frame verdict at end of frame; address match covers non-hash filters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_accept <= 1'b0;
      rx_reject <= 1'b0;
      fcs_err_count <= 1'b0;
    end else begin
      rx_accept <= 1'b0;
      rx_reject <= 1'b0;
      fcs_err_count <= 1'b0;
      if (rx_frame.done && net_ctrl[`EMCC_CTL_RX_EN]) begin
        if ((!rx_frame.crc_ok && !net_cfg[`EMCC_CFG_IGNORE_FCS])
            || (rx_frame.length > max_len)
            || (net_cfg[`EMCC_CFG_LEN_CHECK] && rx_frame.len_field < `EMCC_LEN_TYPE_MIN
                && {2'h0, rx_frame.length} < rx_frame.len_field)
            || !(rx_frame.addr_match
                 || (rx_frame.unicast && net_cfg[`EMCC_CFG_UCAST_HASH]
                     && hash[rx_frame.hash_idx])
                 || (rx_frame.multicast && net_cfg[`EMCC_CFG_MCAST_HASH]
                     && hash[rx_frame.hash_idx]))) begin
          rx_reject <= 1'b1;
        end else begin
          rx_accept <= 1'b1;
        end
        fcs_err_count <= !rx_frame.crc_ok && !net_cfg[`EMCC_CFG_IGNORE_FCS];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_col_seen <= 1'b0;
      tx_crs_seen <= 1'b0;
      rx_allowed <= 1'b0;
    end else begin
      tx_col_seen <= core_rx.collision && !full_duplex;
      tx_crs_seen <= core_rx.carrier && !full_duplex;
      rx_allowed <= net_ctrl[`EMCC_CTL_RX_EN] && (full_duplex
                    || net_cfg[`EMCC_CFG_RX_WHILE_TX] || !tx_active);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_start <= 1'b0;
      pause_dec <= 1'b0;
      backoff_one_slot <= 1'b0;
    end else begin
      pause_start <= rx_pause_frame && net_cfg[`EMCC_CFG_PAUSE_EN];
      pause_dec <= net_cfg[`EMCC_CFG_RETRY_TEST] ? rx_clk_tick : pause_slot_tick;
      backoff_one_slot <= net_cfg[`EMCC_CFG_RETRY_TEST];
    end
  end

  emcc_mgmt u_mgmt (
    .pclk(pclk),
    .presetn(presetn),
    .port_en(net_ctrl[`EMCC_CTL_MGMT_EN]),
    .div_code(net_cfg[`EMCC_CFG_DIV_LO +: 2]),
    .start(mgmt_start),
    .wdata(pwdata),
    .pin_in(mgmt_data_in),
    .shift_data(mgmt_data),
    .idle(mgmt_idle),
    .done(mgmt_done),
    .pin_level(mgmt_level),
    .clk_out(mgmt_clock_pin),
    .data_out(mgmt_data_out),
    .data_oe_n(mgmt_data_oe_n)
  );

  // Loopback switch is only glitch-free with both paths already off
  emcc_line u_line (
    .pclk(pclk),
    .presetn(presetn),
    .loopback(net_ctrl[`EMCC_CTL_LOOPBACK]),
    .serial(net_cfg[`EMCC_CFG_SERIAL]),
    .core_tx(core_tx_q),
    .pins_rx(pins_rx),
    .pins_tx(pins_tx),
    .core_rx(core_rx),
    .loop_tick(loop_tick)
  );
endmodule

// >>> testbench/emcc_phy_model.sv
// Purpose: Far-side PHY model for the management pin and receive pins
// Assumes: Management data line has a pull-up
// Notes: Counts every clock rise, whether the block drives data or not
module emcc_phy_model
  import emcc_pkg::*;
(
  input wire logic pclk,
  input wire logic mdc,
  input wire logic mdo,
  input wire logic mdo_oe_n,
  output logic mdio,
  output emcc_rx_line_type rx,
  output int bits
);
  logic [3:0] cnt = 4'h0;
  // Released line floats up, never holds the last driven bit
  assign mdio = mdo_oe_n ? 1'b1 : mdo;
  // Idle receive line, data changes every cycle so nothing stale shows
  assign rx = '{data: cnt, default: 1'b0};
  always @(posedge pclk) begin
    cnt <= cnt + 4'h1;
  end
  always @(posedge mdc) begin
    bits <= bits + 1;
  end
endmodule

// >>> testbench/emcc_ctrl_assertions.sv
// Purpose: Port-level checks of the MAC control block
// Assumes: Single pclk domain, presetn active low
// Notes: Bound into every instance of the control block
`include "emcc_defines.svh"
module emcc_ctrl_assertions
  import emcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire emcc_tx_event_type tx_evt,
  input wire emcc_rx_frame_type rx_frame,
  input wire logic rx_pause_frame,
  input wire emcc_tx_line_type pins_tx,
  input wire logic mgmt_clock_pin,
  input wire logic mgmt_data_oe_n,
  input wire logic loop_tick,
  input wire logic stats_clear,
  input wire logic tx_flush,
  input wire logic tx_queue_rewind,
  input wire logic tx_run,
  input wire logic rx_accept,
  input wire logic rx_reject,
  input wire logic pause_start,
  input wire logic force_bad_crc
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctl_wr = psel && penable && pwrite && paddr == `EMCC_ADDR_NET_CTRL;
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_stats_clr: assert property (ctl_wr && pwdata[5] |-> ##[1:2] stats_clear)
    else $error("stats clear not pulsed");
  chk_clr_pulse: assert property (stats_clear |=> !stats_clear)
    else $error("stats clear longer than one cycle");
  chk_tx_flush: assert property (ctl_wr && !pwdata[3] && tx_run |-> ##[1:2] tx_flush)
    else $error("tx flush missing");
  chk_rewind_too: assert property (tx_flush |-> tx_queue_rewind)
    else $error("queue rewind missing with flush");
  chk_mgmt_off: assert property (ctl_wr && !pwdata[4] |-> ##3 (!mgmt_clock_pin && mgmt_data_oe_n))
    else $error("management pins active while disabled");
  chk_bad_crc: assert property (tx_evt.underrun || tx_evt.buf_exhausted |=> force_bad_crc)
    else $error("bad crc not forced");
  chk_pause_src: assert property (pause_start |-> $past(rx_pause_frame))
    else $error("pause without pause frame");
  chk_rx_verdict: assert property (rx_accept || rx_reject |-> $past(rx_frame.done) && !(rx_accept && rx_reject))
    else $error("bad receive verdict");
  chk_loop_gap: assert property (loop_tick |=> !loop_tick [*3])
    else $error("loop tick not every fourth cycle");
  chk_loop_pins: assert property (loop_tick |-> !pins_tx.enable && !pins_tx.error)
    else $error("line pins driven in loopback");
endmodule
bind emcc_ctrl emcc_ctrl_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .tx_evt, .rx_frame, .rx_pause_frame, .pins_tx, .mgmt_clock_pin,
  .mgmt_data_oe_n, .loop_tick, .stats_clear, .tx_flush, .tx_queue_rewind, .tx_run, .rx_accept,
  .rx_reject, .pause_start, .force_bad_crc);

// >>> testbench/emcc_ctrl_tb.sv
// Purpose: Self-checking bench of the MAC control block
// Assumes: APB master in the bench, PHY model on the far side
// Notes: Pulse outputs are counted, counts compared after the scenarios that pulse them
`include "emcc_defines.svh"
module emcc_ctrl_tb
  import emcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxp, se, tz;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  emcc_tx_line_type ctx, ptx;
  emcc_tx_event_type ev;
  emcc_rx_frame_type rf;
  emcc_rx_line_type prx, crx;
  logic mck, mdo, moe_n, mdi, sclr, txf, rxf, acc, pst, bcrc, mdone;
  int fails = 0, n_tests = 0, bits;
  int c_sclr = 0, c_txf = 0, c_rxf = 0, c_acc = 0, c_pst = 0, c_crc = 0, c_done = 0;
  emcc_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .core_tx(ctx), .tx_evt(ev), .tx_active(tz), .rx_frame(rf), .rx_pause_frame(rxp),
    .pause_slot_tick(tz), .rx_clk_tick(tz), .pins_rx(prx), .mgmt_data_in(mdi), .pins_tx(ptx),
    .core_rx(crx), .mgmt_clock_pin(mck), .mgmt_data_out(mdo), .mgmt_data_oe_n(moe_n),
    .loop_tick(), .stats_clear(sclr), .tx_flush(txf), .tx_queue_rewind(), .rx_flush(rxf),
    .tx_run(), .rx_run(), .rx_accept(acc), .rx_reject(), .fcs_err_count(), .tx_col_seen(),
    .tx_crs_seen(), .rx_allowed(), .pause_start(pst), .pause_dec(), .backoff_one_slot(),
    .force_bad_crc(bcrc), .mgmt_done(mdone));
  emcc_phy_model phy (.pclk, .mdc(mck), .mdo, .mdo_oe_n(moe_n), .mdio(mdi), .rx(prx), .bits);
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    c_sclr += sclr;
    c_txf += txf;
    c_rxf += rxf;
    c_acc += acc;
    c_pst += pst;
    c_crc += bcrc;
    c_done += mdone;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task t_regs();
    apb(0, `EMCC_ADDR_NET_CFG, 0);
    chk("cfg reset", `EMCC_CFG_RESET, q);
    apb(0, `EMCC_ADDR_NET_STAT, 0);
    chk("idle and pin", 32'h6, q & 32'h6);
    apb(1, `EMCC_ADDR_NET_CFG, 32'hFFFFFFFF);
    apb(0, `EMCC_ADDR_NET_CFG, 0);
    chk("cfg fields", `EMCC_CFG_RW_MASK, q);
    apb(0, 8'h0C, 0);
    chk("unmapped", 32'h1, {q[30:0], se});
  endtask
  task t_ctrl();
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h1C);
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h30);
    repeat (3) @(posedge pclk);
    chk("flushes", 32'h111, {c_sclr[3:0], c_txf[3:0], c_rxf[3:0]});
    apb(0, `EMCC_ADDR_NET_CTRL, 0);
    chk("ctrl read", 32'h10, q);
  endtask
  task pulse(input emcc_tx_event_type e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= '0;
    @(posedge pclk);
  endtask
  task t_txs();
    pulse('{done: 1'b1, default: 1'b0});
    apb(1, `EMCC_ADDR_TX_STAT, 0);
    apb(0, `EMCC_ADDR_TX_STAT, 0);
    chk("tx done", 32'h20, q);
    apb(1, `EMCC_ADDR_TX_STAT, 32'hFF);
    apb(0, `EMCC_ADDR_TX_STAT, 0);
    chk("tx w1c", 32'h0, q);
    ctx <= '{enable: 1'b1, default: 1'b0};
    pulse('{underrun: 1'b1, buf_exhausted: 1'b1, default: 1'b0});
    repeat (3) @(posedge pclk);
    chk("err pin", 32'h1, ptx.error);
    chk("bad crc", 32'h1, c_crc);
    ctx <= '0;
    apb(0, `EMCC_ADDR_TX_STAT, 0);
    chk("tx errs", 32'h50, q);
  endtask
  task automatic t_rx();
    logic [31:0] cf[5] = '{0, 32'h80000, 0, 32'h100, 32'h100};
    logic [13:0] ln[5] = '{64, 64, 1519, 1536, 1537};
    logic ok[5] = '{0, 1, 0, 1, 0};
    int b;
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h04);
    for (int i = 0; i < 5; i++) begin
      apb(1, `EMCC_ADDR_NET_CFG, cf[i]);
      b = c_acc;
      @(posedge pclk);
      rf <= '{done: 1'b1, crc_ok: (i > 1), length: ln[i], len_field: 16'h0800,
        addr_match: 1'b1, default: '0};
      @(posedge pclk);
      rf <= '0;
      repeat (3) @(posedge pclk);
      chk("rx accept", ok[i], c_acc - b);
    end
    apb(1, `EMCC_ADDR_NET_CFG, 32'h2000);
    @(posedge pclk);
    rxp <= 1;
    @(posedge pclk);
    rxp <= 0;
    repeat (2) @(posedge pclk);
    chk("pause", 32'h1, c_pst);
  endtask
  task t_loop();
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h0);
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h2);
    apb(1, `EMCC_ADDR_NET_CTRL, 32'hE);
    ctx <= '{data: 4'hA, enable: 1'b1, default: 1'b0};
    repeat (12) @(posedge pclk);
    chk("loop data", 32'h150, {crx.data, crx.valid, ptx.enable, 3'h0});
    ctx <= '0;
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h2);
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h0);
  endtask
  task t_mgmt();
    int n;
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h10);
    apb(1, `EMCC_ADDR_NET_CFG, 32'h0);
    apb(1, `EMCC_ADDR_MGMT_SHIFT, 32'h50020000);
    apb(0, `EMCC_ADDR_NET_STAT, 0);
    chk("busy", 32'h0, q[2]);
    for (n = 0; n < 200 && q[2] !== 1'b1; n++) apb(0, `EMCC_ADDR_NET_STAT, 0);
    chk("frame", 32'h201, {bits[7:0], c_done[3:0]});
    apb(1, `EMCC_ADDR_NET_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk("port off", 32'h1, {mck, moe_n});
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1ms;
    fails++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, rxp, tz} = '0;
    paddr = '0;
    pwdata = '0;
    ctx = '0;
    ev = '0;
    rf = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_ctrl();
    t_txs();
    t_rx();
    t_loop();
    t_mgmt();
    finish_test();
  end
endmodule
